// file: tb/meter_host_register_interface_properties.sv
// Port-level checker for the meter register bank.
module meter_host_register_interface_properties #(
  parameter int unsigned GATE_CYCLES = 20 // Counter gate length in clocks.
) (
  input wire logic sys_clk_in, // Clock.
  input wire logic reset_n_in, // Reset, active low.
  input wire logic cs_n_in, // Chip select.
  input wire logic rd_n_in, // Read strobe.
  input wire logic ale_in, // Address latch.
  input wire logic [15:0] fast_adc_result_in, // Fast result.
  input wire logic fast_adc_valid_in, // Fast result strobe.
  input wire logic comparator1_in, // Comparator 1.
  input wire logic ad_oe_out, // Bus drive enable.
  input wire logic [7:0] range_mode_select_out, // Register 0.
  input wire logic [7:0] function_network_enables_out, // Register 4.
  input wire logic [7:0] converter_gain_control_out, // Register 5.
  input wire logic [7:0] clock_counter_peak_control_out, // Register 7.
  input wire logic [7:0] buzzer_comparator_misc_out, // Register 8.
  input wire logic converter_on_out, // Converter enable.
  input wire logic schmitt_enable_out, // Hysteresis enable.
  input wire logic beeper_on_out, // Beeper request.
  input wire logic [15:0] positive_peak_out, // Positive peak.
  input wire logic [15:0] negative_peak_out // Negative peak.
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic live_w, up_w, dn_w;
  // Tracker running, and whether the present result beats a stored peak.
  assign live_w = clock_counter_peak_control_out[0];
  assign up_w = live_w && fast_adc_valid_in && $signed(fast_adc_result_in) > $signed(positive_peak_out);
  assign dn_w = live_w && fast_adc_valid_in && $signed(fast_adc_result_in) < $signed(negative_peak_out);
  ////////////////////////////////////////////////////////////////////////////////
  // The bus is driven only for a selected read, so a host write can never collide.
  a_oe_read_only: assert property (ad_oe_out |-> !$past(cs_n_in) && !$past(rd_n_in) && !$past(ale_in))
    else $error("bus driven outside a selected read");
  a_oe_read_start: assert property (!cs_n_in && !rd_n_in && !ale_in |=> ad_oe_out)
    else $error("bus not driven during a selected read");
  a_peak_clear: assert property (!live_w |=> positive_peak_out == 16'h8000 && negative_peak_out == 16'h7fff)
    else $error("peaks not at extremes while cleared");
  a_pos_peak_up: assert property (up_w |=> positive_peak_out == $past(fast_adc_result_in))
    else $error("positive peak missed a larger result");
  a_neg_peak_down: assert property (dn_w |=> negative_peak_out == $past(fast_adc_result_in))
    else $error("negative peak missed a smaller result");
  a_peak_hold_still: assert property (live_w && !fast_adc_valid_in |=> $stable(positive_peak_out) &&
    $stable(negative_peak_out)) else $error("peak moved without a new result");
  a_enable_follow: assert property (1'b1 |=> converter_on_out == $past(converter_gain_control_out[7]) &&
    schmitt_enable_out == $past(function_network_enables_out[3])) else $error("enable output off its bit");
  a_beeper_mix: assert property (1'b1 |=> beeper_on_out == ($past(clock_counter_peak_control_out[7]) &
    ($past(comparator1_in) | ~$past(buzzer_comparator_misc_out[3])))) else $error("beeper request wrong");
  a_reg_quiet: assert property (cs_n_in [*4] |-> $stable(range_mode_select_out) &&
    $stable(clock_counter_peak_control_out)) else $error("register changed while deselected");
  c_peak_rise: cover property (up_w);
  c_beeper_on: cover property (beeper_on_out);
  c_bus_read: cover property (!cs_n_in && !rd_n_in);
endmodule
bind meter_host_register_interface meter_host_register_interface_properties #(.GATE_CYCLES(GATE_CYCLES)) chk_u (.*);

// file: tb/meter_host_register_interface_tb.sv
// Self-checking bench for the meter register bank.
module meter_host_register_interface_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int GATE = 20;
  logic clk = 1'b0, rst_n = 1'b0, sig = 1'b0, fv = 1'b0, hv = 1'b0, sq = 1'b0;
  logic [2:0] st = 3'h0;
  logic [15:0] fres = 16'h0000;
  logic cs_n, wr_n, rd_n, ale, hoe, doe, irq_n, conv, schm, cmp_hi, beep;
  logic [3:0] had, dad, bus;
  logic [7:0] ro [9];
  logic [7:0] model [9];
  logic [7:0] rv;
  logic [15:0] pos, neg;
  logic [23:0] tbc, sgc;
  int bad_count = 0, n_compared = 0, cycles = 0, pk, nk;
  nibble_host_model host_u (.clk_in(clk), .bus_in(bus), .cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n),
    .ale_out(ale), .ad_out(had), .oe_out(hoe));
  meter_host_register_interface #(.GATE_CYCLES(GATE)) dut_u (.sys_clk_in(clk), .reset_n_in(rst_n), .cs_n_in(cs_n),
    .wr_n_in(wr_n), .rd_n_in(rd_n), .ale_in(ale), .ad_in(bus), .ad_out(dad), .ad_oe_out(doe), .interrupt_out_n(irq_n),
    .signal_in(sig), .fast_adc_result_in(fres), .fast_adc_valid_in(fv), .hires_adc_valid_in(hv),
    .comparator1_in(st[1]), .comparator2_in(st[2]), .low_battery_in(st[0]), .range_mode_select_out(ro[0]),
    .adc_input_path_select_out(ro[1]), .adc_reference_path_select_out(ro[2]), .comparator_mux_control_out(ro[3]),
    .function_network_enables_out(ro[4]), .converter_gain_control_out(ro[5]), .converter_setup_out(ro[6]),
    .clock_counter_peak_control_out(ro[7]), .buzzer_comparator_misc_out(ro[8]), .converter_on_out(conv),
    .schmitt_enable_out(schm), .comparator_high_direct_out(cmp_hi), .beeper_on_out(beep), .timebase_count_out(tbc),
    .signal_count_out(sgc), .positive_peak_out(pos), .negative_peak_out(neg));
  // A released bus shows the inverse of the last host nibble, so a stale value cannot pass.
  assign bus = doe ? dad : (hoe ? had : ~had);
  always #2 clk = ~clk;
  // Random counter input, and a cycle limit against a hang.
  // While counts are checked the input is a period-four square wave, so any gate of a
  // multiple of four clocks holds a known number of edges and high clocks wherever it starts.
  always @(posedge clk) begin
    sig <= #1 sq ? cycles[1] : 1'($urandom);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_reg(input int a, input logic [7:0] exp);
    logic [7:0] v;
    host_u.rd_reg(4'(a), v);
    chk($sformatf("read of register %0d", a), {8'h00, exp}, {8'h00, v});
  endtask
  // Register ports and the control lines derived from them.
  task automatic chk_ports();
    for (int a = 0; a < 9; a++) chk($sformatf("port %0d", a), {8'h00, model[a]}, {8'h00, ro[a]});
    chk("converter on", 16'(model[5][7]), 16'(conv));
    chk("schmitt", 16'(model[4][3]), 16'(schm));
    chk("direct input", 16'(model[8][2]), 16'(cmp_hi));
    chk("beeper", 16'(model[7][7] & (st[1] | ~model[8][3])), 16'(beep));
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    void'($urandom(95246));
    tick(3);
    rst_n = 1'b1;
    for (int a = 0; a < 9; a++) model[a] = 8'h00;
    chk("irq", 16'h0001, 16'(irq_n));
    for (int a = 0; a < 10; a++) chk_reg(a, 8'h00);
    chk_ports();
    // Counter and tracker bits stay low here so no measurement starts.
    repeat (4) begin
      for (int a = 0; a < 9; a++) begin
        rv = 8'($urandom) & ((a == 7) ? 8'hfc : 8'hff);
        host_u.wr_reg(4'(a), rv, 1'b1);
        model[a] = (a == 8) ? (rv & 8'h8f) : rv;
      end
      st = 3'($urandom);
      tick(2);
      for (int a = 0; a < 9; a++) chk_reg(a, model[a] | ((a == 8) ? {1'b0, st, 4'h0} : 8'h00));
      chk_ports();
    end
    // Deselected write, unmapped address, and a lone upper nibble cut off by a new latch.
    host_u.wr_reg(4'h0, ~model[0], 1'b0);
    host_u.wr_reg(4'ha, 8'h5a, 1'b1);
    chk_reg(10, 8'h00);
    chk_reg(0, model[0]);
    host_u.step(5'b01111, 4'h1, 1);
    host_u.step(5'b00011, 4'hc, 2);
    host_u.step(5'b00111, 4'hc, 2);
    host_u.wr_reg(4'h1, 8'h3b, 1'b1);
    model[1] = 8'h3b;
    chk_reg(1, 8'h3b);
    // All interrupts enabled; the flag half of the register ignores the write.
    host_u.wr_reg(4'h9, 8'hff, 1'b1);
    hv = 1'b1;
    tick(1);
    hv = 1'b0;
    tick(2);
    chk("irq", 16'h0000, 16'(irq_n));
    chk_reg(9, 8'h1f);
    chk_reg(9, 8'h0f);
    chk("irq", 16'h0001, 16'(irq_n));
    // The interrupt register after the first restart is read and thrown away, then one count in each mode.
    sq = 1'b1;
    host_u.wr_reg(4'h7, 8'h00, 1'b1);
    host_u.wr_reg(4'h7, 8'h02, 1'b1);
    tick(GATE + 8);
    host_u.rd_reg(4'h9, rv);
    for (int d = 0; d < 2; d++) begin
      host_u.wr_reg(4'h7, 8'(4 * d), 1'b1);
      host_u.wr_reg(4'h7, 8'(4 * d + 2), 1'b1);
      chk("irq", 16'h0001, 16'(irq_n));
      tick(GATE + 8);
      chk("irq", 16'h0000, 16'(irq_n));
      chk_reg(9, 8'h8f);
      chk("timebase count", 16'(GATE), tbc[15:0]);
      chk("signal count", 16'(GATE / (4 - 2 * d)), sgc[15:0]);
      chk("count upper bits", 16'h0000, {tbc[23:16], sgc[23:16]});
    end
    sq = 1'b0;
    // Tracker cleared, released, then fed random signed results.
    host_u.wr_reg(4'h7, 8'h00, 1'b1);
    chk("positive peak", 16'h8000, pos);
    chk("negative peak", 16'h7fff, neg);
    host_u.wr_reg(4'h7, 8'h01, 1'b1);
    model[7] = 8'h01;
    pk = -32768;
    nk = 32767;
    repeat (12) begin
      fres = 16'($urandom);
      fv = 1'b1;
      tick(1);
      fv = 1'b0;
      tick(1);
      if ($signed(fres) > pk) pk = $signed(fres);
      if ($signed(fres) < nk) nk = $signed(fres);
      chk("positive peak", 16'(pk), pos);
      chk("negative peak", 16'(nk), neg);
    end
    chk_reg(9, 8'h6f);
    chk_ports();
    // A mid-run chip reset must clear the bank, flags and tracker again.
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    for (int a = 0; a < 9; a++) model[a] = 8'h00;
    chk_ports();
    chk("irq", 16'h0001, 16'(irq_n));
    chk("positive peak", 16'h8000, pos);
    chk_reg(9, 8'h00);
    end_sim();
  end
endmodule

// file: tb/nibble_host_model.sv
// Host processor model on the multiplexed nibble bus.
module nibble_host_model (
  input wire logic clk_in, // Bus clock.
  input wire logic [3:0] bus_in, // Resolved bus lines.
  output logic cs_n_out, // Chip select, active low.
  output logic wr_n_out, // Write strobe, active low.
  output logic rd_n_out, // Read strobe, active low.
  output logic ale_out, // Address latch strobe.
  output logic [3:0] ad_out, // Nibble driven by the host.
  output logic oe_out // High while the host drives.
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle from time zero: deselected, read and write strobes high, latch strobe low, bus released.
  initial begin
    {cs_n_out, ale_out, wr_n_out, rd_n_out, oe_out} = 5'b10110;
    ad_out = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Pins change just after an edge and hold for n edges; a released nibble keeps its old value.
  task automatic step(input logic [4:0] pins, input logic [3:0] ad, input int n);
    {cs_n_out, ale_out, wr_n_out, rd_n_out, oe_out} = pins;
    if (pins[0]) ad_out = ad;
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Strobes stay two edges low and two high, since the bank samples them on the clock.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d, input logic sel);
    step({~sel, 4'b1111}, a, 1);
    step({~sel, 4'b0111}, a, 1);
    for (int i = 1; i >= 0; i--) begin
      step({~sel, 4'b0011}, d[4*i +: 4], 2);
      step({~sel, 4'b0111}, d[4*i +: 4], 2);
    end
    step(5'b10110, a, 1);
  endtask
  // Read: upper nibble then lower, each taken while the strobe is still low.
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    step(5'b01111, a, 1);
    for (int i = 1; i >= 0; i--) begin
      step(5'b00100, a, 2);
      d[4*i +: 4] = bus_in;
      step(5'b00110, a, 2);
    end
    step(5'b10110, a, 1);
  endtask
endmodule

// file: verilog/meter_defines.svh
// Register offsets, field positions, reset values and timing figures of the meter host interface.
`ifndef METER_DEFINES_SVH
`define METER_DEFINES_SVH

// Register addresses on the nibble bus.
`define ADDR_RANGE_MODE 4'h0
`define ADDR_ADC_INPUT 4'h1
`define ADDR_ADC_REF 4'h2
`define ADDR_CMP_MUX 4'h3
`define ADDR_FUNC_NET 4'h4
`define ADDR_CONV_GAIN 4'h5
`define ADDR_CONV_SETUP 4'h6
`define ADDR_CLK_CNT_PEAK 4'h7
`define ADDR_MISC 4'h8
`define ADDR_INT 4'h9
`define NUM_CTRL_REGS 9
`define CTRL_RESET 8'h00

// Field positions.
`define BIT_BEEPER_ENABLE 7
`define BIT_DUTY_MODE 2
`define BIT_COUNTER_RESTART_N 1
`define BIT_PEAK_CLEAR_N 0
`define BIT_SCHMITT_ENABLE 3
`define BIT_CONVERTER_ON 7
`define BIT_BEEP_COUNT_CTL 3
`define BIT_CMP_HIGH_DIRECT 2
`define MISC_WRITABLE_MASK 8'h8f
`define INT_FLAG_COUNTER 3
`define INT_FLAG_PEAK 2
`define INT_FLAG_FAST_ADC 1
`define INT_FLAG_HIRES_ADC 0

// Peak tracker reset values, extremes of a signed 16-bit result.
`define PEAK_MOST_NEGATIVE 16'h8000
`define PEAK_MOST_POSITIVE 16'h7fff

// Counter gate time and clock rate.
`define COUNTER_GATE_US 200000
`define CLK_MHZ 250

`endif

// file: verilog/meter_host_register_interface.sv
// Nibble-bus register bank, frequency/duty counter and peak tracker of the meter front end.
`include "meter_defines.svh"

module meter_host_register_interface #(
  parameter int unsigned GATE_CYCLES = `COUNTER_GATE_US * `CLK_MHZ // Counter gate length in clocks.
) (
  input wire logic sys_clk_in, // System clock, 250 MHz.
  input wire logic reset_n_in, // Chip reset, active low.
  input wire logic cs_n_in, // Chip select, active low.
  input wire logic wr_n_in, // Write strobe, active low.
  input wire logic rd_n_in, // Read strobe, active low.
  input wire logic ale_in, // Address latch strobe, active high.
  input wire logic [3:0] ad_in, // Multiplexed address/data lines, input side.
  output logic [3:0] ad_out, // Multiplexed data lines, output side.
  output logic ad_oe_out, // High while the block drives the data lines.
  output logic interrupt_out_n, // Interrupt request, active low.
  input wire logic signal_in, // Conditioned input for the counter.
  input wire logic [15:0] fast_adc_result_in, // Fast converter result, signed.
  input wire logic fast_adc_valid_in, // One-cycle pulse with each new fast result.
  input wire logic hires_adc_valid_in, // One-cycle pulse with each new high-resolution result.
  input wire logic comparator1_in, // Comparator 1 output.
  input wire logic comparator2_in, // Comparator 2 output.
  input wire logic low_battery_in, // Low-battery detector output.
  output logic [7:0] range_mode_select_out, // Register 0.
  output logic [7:0] adc_input_path_select_out, // Register 1.
  output logic [7:0] adc_reference_path_select_out, // Register 2.
  output logic [7:0] comparator_mux_control_out, // Register 3.
  output logic [7:0] function_network_enables_out, // Register 4.
  output logic [7:0] converter_gain_control_out, // Register 5.
  output logic [7:0] converter_setup_out, // Register 6.
  output logic [7:0] clock_counter_peak_control_out, // Register 7.
  output logic [7:0] buzzer_comparator_misc_out, // Register 8 writable bits.
  output logic converter_on_out, // Converter enable.
  output logic schmitt_enable_out, // Comparator hysteresis enable.
  output logic comparator_high_direct_out, // Comparator high input taken from the AC pin.
  output logic beeper_on_out, // Beeper drive request.
  output logic [23:0] timebase_count_out, // Timebase count of the last finished measurement.
  output logic [23:0] signal_count_out, // Signal or duty count of the last finished measurement.
  output logic [15:0] positive_peak_out, // Highest fast result since release.
  output logic [15:0] negative_peak_out // Lowest fast result since release.
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus strobe edges and register storage.
  meter_pkg::byte_t ctrl_r [`NUM_CTRL_REGS];
  meter_pkg::nibble_t addr_r;
  meter_pkg::nibble_t hold_r;
  logic upper_next_r;
  logic wr_n_prev_r;
  logic rd_n_prev_r;
  logic [3:0] flags_r;
  logic [3:0] flags_seen_r;
  logic [3:0] int_enable_r;
  logic [3:0] ad_out_r;
  logic ad_oe_r;
  logic irq_n_r;
  logic wr_fall;
  logic rd_rise;
  logic int_read_done;
  logic [3:0] flag_set;
  meter_pkg::byte_t rd_byte;

  // Strobe edges count only while the chip is selected.
  assign wr_fall = wr_n_prev_r & ~wr_n_in & ~cs_n_in;
  assign rd_rise = ~rd_n_prev_r & rd_n_in & ~cs_n_in;

  // The interrupt register is released once its lower nibble has been read.
  assign int_read_done = rd_rise & ~upper_next_r & (addr_r == `ADDR_INT);

  // Previous strobe levels for edge detection.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_n_prev_r <= 1'b1;
      rd_n_prev_r <= 1'b1;
    end else begin
      wr_n_prev_r <= wr_n_in;
      rd_n_prev_r <= rd_n_in;
    end
  end

  // Address latch and nibble sequencing; the latch strobe always restarts at the upper nibble.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      addr_r <= 4'h0;
      upper_next_r <= 1'b1;
      hold_r <= 4'h0;
    end else if (ale_in) begin
      addr_r <= ad_in;
      upper_next_r <= 1'b1;
    end else if (wr_fall) begin
      if (upper_next_r) begin
        hold_r <= ad_in;
      end
      upper_next_r <= ~upper_next_r;
    end else if (rd_rise) begin
      upper_next_r <= ~upper_next_r;
    end
  end

  // Control register writes commit on the lower nibble.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < `NUM_CTRL_REGS; i++) begin
        ctrl_r[i] <= `CTRL_RESET;
      end
    end else if (wr_fall && !ale_in && !upper_next_r && addr_r < `ADDR_INT) begin
      ctrl_r[addr_r] <= {hold_r, ad_in};
    end
  end

  // Interrupt enables sit in the low half of register 9 and are read/write.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_enable_r <= 4'h0;
    end else if (wr_fall && !ale_in && !upper_next_r && addr_r == `ADDR_INT) begin
      int_enable_r <= ad_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data path.
  // Misc bits 6:4 are live status; the remaining bits come from storage.
  always_comb begin
    rd_byte = 8'h00;
    if (addr_r < `ADDR_INT) begin
      rd_byte = ctrl_r[addr_r];
    end
    if (addr_r == `ADDR_MISC) begin
      rd_byte = (ctrl_r[`ADDR_MISC] & `MISC_WRITABLE_MASK) |
                {1'b0, comparator2_in, comparator1_in, low_battery_in, 4'h0};
    end else if (addr_r == `ADDR_INT) begin
      rd_byte = {flags_r, int_enable_r};
    end
  end

  // The data lines are driven one clock after the chip is selected with the read strobe low and the latch strobe low.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ad_out_r <= 4'h0;
      ad_oe_r <= 1'b0;
    end else begin
      ad_out_r <= upper_next_r ? rd_byte[7:4] : rd_byte[3:0];
      ad_oe_r <= ~cs_n_in & ~rd_n_in & ~ale_in;
    end
  end

  assign ad_out = ad_out_r;
  assign ad_oe_out = ad_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags.
  logic counter_done;
  logic peak_event;

  assign flag_set = {counter_done, peak_event, fast_adc_valid_in, hires_adc_valid_in};

  // Only flags already shown on the upper nibble are released, so an event that lands
  // during the read is not lost; a set in the clearing cycle also wins.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_r <= 4'h0;
      flags_seen_r <= 4'h0;
    end else begin
      if (rd_rise && upper_next_r && addr_r == `ADDR_INT) begin
        flags_seen_r <= flags_r;
      end
      if (int_read_done) begin
        flags_r <= (flags_r & ~flags_seen_r) | flag_set;
      end else begin
        flags_r <= flags_r | flag_set;
      end
    end
  end

  // Enables only gate the pin; the flags update regardless.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= ~|(flags_r & int_enable_r);
    end
  end

  assign interrupt_out_n = irq_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Frequency and duty counter.
  meter_pkg::counter_state_e cnt_state_r;
  logic restart_prev_r;
  logic signal_prev_r;
  logic [31:0] gate_r;
  logic [23:0] tb_cnt_r;
  logic [23:0] sg_cnt_r;
  logic [23:0] tb_out_r;
  logic [23:0] sg_out_r;
  logic done_r;
  logic restart_n;
  logic duty_mode;
  logic signal_tick;

  assign restart_n = ctrl_r[`ADDR_CLK_CNT_PEAK][`BIT_COUNTER_RESTART_N];
  assign duty_mode = ctrl_r[`ADDR_CLK_CNT_PEAK][`BIT_DUTY_MODE];
  // Frequency mode counts rising edges, duty mode counts high clocks.
  assign signal_tick = duty_mode ? signal_in : (signal_in & ~signal_prev_r);
  assign counter_done = done_r;

  // A restart is the rising edge of the restart bit; clearing the bit aborts a running count.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      restart_prev_r <= 1'b0;
      signal_prev_r <= 1'b0;
      cnt_state_r <= meter_pkg::CNT_IDLE;
      gate_r <= 32'h0000_0000;
      tb_cnt_r <= 24'h00_0000;
      sg_cnt_r <= 24'h00_0000;
      done_r <= 1'b0;
    end else begin
      restart_prev_r <= restart_n;
      signal_prev_r <= signal_in;
      done_r <= 1'b0;
      unique case (cnt_state_r)
        meter_pkg::CNT_IDLE: begin
          if (restart_n && !restart_prev_r) begin
            cnt_state_r <= meter_pkg::CNT_RUN;
            gate_r <= 32'(GATE_CYCLES);
            tb_cnt_r <= 24'h00_0000;
            sg_cnt_r <= 24'h00_0000;
          end
        end
        meter_pkg::CNT_RUN: begin
          if (!restart_n) begin
            cnt_state_r <= meter_pkg::CNT_IDLE;
          end else begin
            tb_cnt_r <= tb_cnt_r + 24'h00_0001;
            sg_cnt_r <= sg_cnt_r + {23'h00_0000, signal_tick};
            gate_r <= gate_r - 32'h0000_0001;
            if (gate_r <= 32'h0000_0001) begin
              cnt_state_r <= meter_pkg::CNT_IDLE;
              done_r <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Results are published when the gate closes, so reads never see a count in motion.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tb_out_r <= 24'h00_0000;
      sg_out_r <= 24'h00_0000;
    end else if (cnt_state_r == meter_pkg::CNT_RUN && restart_n && gate_r <= 32'h0000_0001) begin
      tb_out_r <= tb_cnt_r + 24'h00_0001;
      sg_out_r <= sg_cnt_r + {23'h00_0000, signal_tick};
    end
  end

  assign timebase_count_out = tb_out_r;
  assign signal_count_out = sg_out_r;

  ////////////////////////////////////////////////////////////////////////////
  // Peak tracker.
  logic signed [15:0] pos_peak_r;
  logic signed [15:0] neg_peak_r;
  logic peak_event_r;
  logic peak_clear_n;
  logic signed [15:0] sample;

  assign peak_clear_n = ctrl_r[`ADDR_CLK_CNT_PEAK][`BIT_PEAK_CLEAR_N];
  assign sample = signed'(fast_adc_result_in);
  assign peak_event = peak_event_r;

  // Each valid result is compared once; the peak flag rises when either peak moves.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pos_peak_r <= `PEAK_MOST_NEGATIVE;
      neg_peak_r <= `PEAK_MOST_POSITIVE;
      peak_event_r <= 1'b0;
    end else if (!peak_clear_n) begin
      pos_peak_r <= `PEAK_MOST_NEGATIVE;
      neg_peak_r <= `PEAK_MOST_POSITIVE;
      peak_event_r <= 1'b0;
    end else begin
      peak_event_r <= 1'b0;
      if (fast_adc_valid_in) begin
        if (sample > pos_peak_r) begin
          pos_peak_r <= sample;
          peak_event_r <= 1'b1;
        end
        if (sample < neg_peak_r) begin
          neg_peak_r <= sample;
          peak_event_r <= 1'b1;
        end
      end
    end
  end

  assign positive_peak_out = pos_peak_r;
  assign negative_peak_out = neg_peak_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs and derived controls.
  logic conv_on_r;
  logic schmitt_r;
  logic cmp_high_direct_r;
  logic beeper_r;

  // Register contents go out unchanged except register 8, masked to its writable bits; analog fields are decoded outside.
  assign range_mode_select_out = ctrl_r[`ADDR_RANGE_MODE];
  assign adc_input_path_select_out = ctrl_r[`ADDR_ADC_INPUT];
  assign adc_reference_path_select_out = ctrl_r[`ADDR_ADC_REF];
  assign comparator_mux_control_out = ctrl_r[`ADDR_CMP_MUX];
  assign function_network_enables_out = ctrl_r[`ADDR_FUNC_NET];
  assign converter_gain_control_out = ctrl_r[`ADDR_CONV_GAIN];
  assign converter_setup_out = ctrl_r[`ADDR_CONV_SETUP];
  assign clock_counter_peak_control_out = ctrl_r[`ADDR_CLK_CNT_PEAK];
  assign buzzer_comparator_misc_out = ctrl_r[`ADDR_MISC] & `MISC_WRITABLE_MASK;

  // With beep count control set the beeper follows comparator 1, otherwise the enable alone.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      conv_on_r <= 1'b0;
      schmitt_r <= 1'b0;
      cmp_high_direct_r <= 1'b0;
      beeper_r <= 1'b0;
    end else begin
      conv_on_r <= ctrl_r[`ADDR_CONV_GAIN][`BIT_CONVERTER_ON];
      schmitt_r <= ctrl_r[`ADDR_FUNC_NET][`BIT_SCHMITT_ENABLE];
      cmp_high_direct_r <= ctrl_r[`ADDR_MISC][`BIT_CMP_HIGH_DIRECT];
      beeper_r <= ctrl_r[`ADDR_CLK_CNT_PEAK][`BIT_BEEPER_ENABLE] &
                  (comparator1_in | ~ctrl_r[`ADDR_MISC][`BIT_BEEP_COUNT_CTL]);
    end
  end

  assign converter_on_out = conv_on_r;
  assign schmitt_enable_out = schmitt_r;
  assign comparator_high_direct_out = cmp_high_direct_r;
  assign beeper_on_out = beeper_r;

endmodule

// file: verilog/meter_pkg.sv
// Types shared by the meter host interface.
package meter_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] nibble_t;
  typedef logic [15:0] peak_t;
  typedef enum logic [0:0] {
    CNT_IDLE = 1'b0,
    CNT_RUN = 1'b1
  } counter_state_e;
endpackage
